// File: effective_address_generator.v
// Effective address generator with APB access to its control, status and general registers.
`timescale 1ns/1ps
`include "eag_consts.vh"

module effective_address_generator #(
  parameter NREGS = 8
) (
  input  wire        sys_clk,
  input  wire        nrst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        reqValid,
  input  wire        baseUse,
  input  wire [2:0]  baseSel,
  input  wire        indexUse,
  input  wire [2:0]  indexSel,
  input  wire [1:0]  scaleCode,
  input  wire [1:0]  dispSize,
  input  wire [31:0] dispValue,
  input  wire        opPrefix,
  input  wire        addrPrefix,
  output reg         reqReady,
  output reg         eaValid,
  output reg  [31:0] operandOffset,
  output reg         addrSize32,
  output reg         opSize32,
  output reg         gpFault,
  output reg         formIllegal
);

  // One-hot pipeline states.
  localparam [2:0] S_IDLE   = 3'h1;
  localparam [2:0] S_JOIN   = 3'h2;
  localparam [2:0] S_FINISH = 3'h4;

  reg  [1:0]        rstSync;
  wire              rstN;
  reg  [1:0]        ctrl_reg;
  reg  [31:0]       gpr_reg [0:NREGS-1];
  wire [32*NREGS-1:0] gprFlat;
  reg  [2:0]        state_reg;
  reg  [2:0]        state_next;
  reg  [31:0]       base_reg;
  reg  [31:0]       scaled_reg;
  reg  [31:0]       disp_reg;
  reg  [31:0]       partial_reg;
  reg               addr32_reg;
  reg               op32_reg;
  reg               illegal_reg;
  reg  [31:0]       count_reg;
  reg               lastFault_reg;
  reg               lastIllegal_reg;
  wire              defaultSize32;
  wire              addr32Now;
  wire              op32Now;
  wire [31:0]       baseVal;
  wire [31:0]       indexVal;
  wire              baseBad;
  wire              indexBad;
  reg  [31:0]       scaledVal;
  reg  [31:0]       dispExt;
  reg               dispBad;
  wire [31:0]       sumOut;
  wire              overRange;
  wire              accept;
  wire              apbAccess;
  wire              apbDone;
  wire              gprHit;
  wire [2:0]        gprIdx;
  reg  [31:0]       readMux;
  reg               addrBad;
  integer           i;
  genvar            g;

  // The external reset is asserted at once and released through two flops,
  // so no flop leaves reset on a different edge than its neighbours.
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstN = rstSync[1];

  // Real mode forces 16-bit defaults; otherwise the code segment bit decides.
  assign defaultSize32 = ctrl_reg[`EAG_CTRL_PROT] & ctrl_reg[`EAG_CTRL_DBIT];
  // Each prefix flips its own size for this instruction only.
  assign addr32Now = defaultSize32 ^ addrPrefix;
  assign op32Now   = defaultSize32 ^ opPrefix;

  // Flatten the register file for the two operand ports.
  generate
    for (g = 0; g < NREGS; g = g + 1) begin : flat
      assign gprFlat[g*32 +: 32] = gpr_reg[g];
    end
  endgenerate

  ea_operand_select #(
    .WIDTH   (32),
    .NREGS   (NREGS),
    .ISINDEX (0)
  ) baseSelect (
    .regFlat (gprFlat),
    .sel     (baseSel),
    .useIt   (baseUse),
    .addr32  (addr32Now),
    .value   (baseVal),
    .illegal (baseBad)
  );

  ea_operand_select #(
    .WIDTH   (32),
    .NREGS   (NREGS),
    .ISINDEX (1)
  ) indexSelect (
    .regFlat (gprFlat),
    .sel     (indexSel),
    .useIt   (indexUse),
    .addr32  (addr32Now),
    .value   (indexVal),
    .illegal (indexBad)
  );

  // Scale by 1, 2, 4 or 8 in 32-bit forms only; the 16-bit model has no scale.
  always @* begin
    scaledVal = indexVal;
    if (addr32Now) begin
      case (scaleCode)
        2'h1:    scaledVal = {indexVal[30:0], 1'b0};
        2'h2:    scaledVal = {indexVal[29:0], 2'h0};
        2'h3:    scaledVal = {indexVal[28:0], 3'h0};
        default: scaledVal = indexVal;
      endcase
    end
  end

  // Sign-extend an 8-bit displacement, zero-extend a 16-bit one; a size the current model lacks is refused.
  always @* begin
    dispExt = 32'h00000000;
    dispBad = 1'b0;
    case (dispSize)
      `EAG_DISP_8: begin
        dispExt = {{24{dispValue[7]}}, dispValue[7:0]};
      end
      `EAG_DISP_16: begin
        dispExt = {16'h0000, dispValue[15:0]};
        dispBad = addr32Now;
      end
      `EAG_DISP_32: begin
        dispExt = dispValue;
        dispBad = !addr32Now;
      end
      default: begin
        dispExt = 32'h00000000;
      end
    endcase
  end

  assign accept = reqValid & reqReady;

  // Final adder shared by every form; the partial holds base plus scaled index.
  ea_sum_stage finalSum (
    .partial   (partial_reg),
    .disp      (disp_reg),
    .addr32    (addr32_reg),
    .realMode  (!ctrl_reg[`EAG_CTRL_PROT]),
    .offset    (sumOut),
    .overRange (overRange)
  );

  // Next state: a base together with an index takes one extra join clock.
  always @* begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: begin
        if (accept) begin
          state_next = (baseUse && indexUse) ? S_JOIN : S_FINISH;
        end
      end
      S_JOIN: begin
        state_next = S_FINISH;
      end
      S_FINISH: begin
        state_next = S_IDLE;
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  // Address pipeline. Single-component forms fold into the partial at once;
  // a base plus index pair is added in the join clock before the displacement.
  always @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      state_reg     <= S_IDLE;
      base_reg      <= 32'h00000000;
      scaled_reg    <= 32'h00000000;
      disp_reg      <= 32'h00000000;
      partial_reg   <= 32'h00000000;
      addr32_reg    <= 1'b0;
      op32_reg      <= 1'b0;
      illegal_reg   <= 1'b0;
      reqReady      <= 1'b0;
      eaValid       <= 1'b0;
      operandOffset <= 32'h00000000;
      addrSize32    <= 1'b0;
      opSize32      <= 1'b0;
      gpFault       <= 1'b0;
      formIllegal   <= 1'b0;
    end else begin
      state_reg <= state_next;
      eaValid   <= 1'b0;
      reqReady  <= (state_next == S_IDLE);
      if (accept) begin
        base_reg    <= baseVal;
        scaled_reg  <= scaledVal;
        disp_reg    <= dispExt;
        // Without both components, one of them is zero and the add is trivial.
        partial_reg <= baseUse && indexUse ? 32'h00000000 : baseVal | scaledVal;
        addr32_reg  <= addr32Now;
        op32_reg    <= op32Now;
        illegal_reg <= baseBad | indexBad | dispBad;
      end
      if (state_reg == S_JOIN) begin
        // The join clock adds base and scaled index; the displacement is added in the finish clock.
        partial_reg <= base_reg + scaled_reg;
      end
      if (state_reg == S_FINISH) begin
        eaValid       <= 1'b1;
        operandOffset <= sumOut;
        addrSize32    <= addr32_reg;
        opSize32      <= op32_reg;
        gpFault       <= overRange;
        formIllegal   <= illegal_reg;
      end
    end
  end

  // APB decode. Registers sit at aligned words; anything else is an error.
  assign apbAccess = psel & penable & !pready;
  // Completion edge: the master still holds address, direction and data here.
  assign apbDone   = psel & penable & pready;
  assign gprHit    = (paddr >= `EAG_OFF_GPR_BASE) && (paddr <= `EAG_OFF_GPR_LAST) && (paddr[1:0] == 2'h0);
  assign gprIdx    = paddr[4:2];

  // Read mux and address check for the access phase.
  always @* begin
    readMux = 32'h00000000;
    addrBad = 1'b0;
    if (gprHit) begin
      readMux = gpr_reg[gprIdx];
    end else begin
      case (paddr)
        `EAG_OFF_CTRL: begin
          readMux = {30'h00000000, ctrl_reg};
        end
        `EAG_OFF_STATUS: begin
          readMux = {27'h0000000, (state_reg != S_IDLE), op32_reg, addr32_reg, lastIllegal_reg, lastFault_reg};
        end
        `EAG_OFF_RESULT: begin
          readMux = operandOffset;
        end
        `EAG_OFF_COUNT: begin
          readMux = count_reg;
        end
        default: begin
          addrBad = 1'b1;
        end
      endcase
    end
  end

  // APB slave: pready rises one clock into the access phase, so every
  // transfer is setup, one wait clock, then completion. The status
  // register is read-only; writes to it and to unmapped words raise pslverr.
  always @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      prdata   <= 32'h00000000;
      ctrl_reg <= `EAG_CTRL_RESET;
      for (i = 0; i < NREGS; i = i + 1) begin
        gpr_reg[i] <= 32'h00000000;
      end
    end else begin
      pready  <= apbAccess;
      pslverr <= apbAccess & (addrBad | (pwrite & (paddr == `EAG_OFF_STATUS)));
      prdata  <= (apbAccess & !pwrite) ? readMux : 32'h00000000;
      // Writes land only at the completion edge, never during the wait clock.
      if (apbDone & pwrite & !addrBad) begin
        if (gprHit) begin
          gpr_reg[gprIdx] <= pwdata;
        end else if (paddr == `EAG_OFF_CTRL) begin
          ctrl_reg <= pwdata[1:0];
        end
      end
    end
  end

  // Sticky fault and illegal-form flags plus a completion counter.
  // A new completion wins over a software clear in the same clock.
  always @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      lastFault_reg   <= 1'b0;
      lastIllegal_reg <= 1'b0;
      count_reg       <= 32'h00000000;
    end else begin
      if (apbDone & pwrite & (paddr == `EAG_OFF_COUNT)) begin
        count_reg       <= 32'h00000000;
        lastFault_reg   <= 1'b0;
        lastIllegal_reg <= 1'b0;
      end
      if (state_reg == S_FINISH) begin
        count_reg <= count_reg + 32'h00000001;
        if (overRange) begin
          lastFault_reg <= 1'b1;
        end
        if (illegal_reg) begin
          lastIllegal_reg <= 1'b1;
        end
      end
    end
  end

endmodule // effective_address_generator

// File: eag_consts.vh
// Constants for the effective address generator: register map, fields and encodings.
`ifndef EAG_CONSTS_VH
`define EAG_CONSTS_VH

// APB register byte offsets.
`define EAG_OFF_CTRL       8'h00
`define EAG_OFF_STATUS     8'h04
`define EAG_OFF_RESULT     8'h08
`define EAG_OFF_COUNT      8'h0C
`define EAG_OFF_GPR_BASE   8'h20
`define EAG_OFF_GPR_LAST   8'h3C

// Control register fields and reset value.
`define EAG_CTRL_DBIT      0
`define EAG_CTRL_PROT      1
`define EAG_CTRL_RESET     2'h0

// Status register fields.
`define EAG_ST_FAULT       0
`define EAG_ST_ILLEGAL     1
`define EAG_ST_ADDR32      2
`define EAG_ST_OP32        3
`define EAG_ST_BUSY        4

// General register numbers used by the legacy 16-bit model and the 32-bit model.
`define EAG_REG_STACK      3'h4
`define EAG_REG_BX         3'h3
`define EAG_REG_BP         3'h5
`define EAG_REG_SI         3'h6
`define EAG_REG_DI         3'h7

// Displacement size codes.
`define EAG_DISP_NONE      2'h0
`define EAG_DISP_8         2'h1
`define EAG_DISP_16        2'h2
`define EAG_DISP_32        2'h3

// Real-mode offset ceiling and the 16-bit offset mask.
`define EAG_REAL_LIMIT     32'h0000FFFF
`define EAG_MASK16         32'h0000FFFF

`endif

// File: ea_operand_select.v
// One operand port: picks a general register and checks it against the addressing model.
`timescale 1ns/1ps
`include "eag_consts.vh"

module ea_operand_select #(
  parameter WIDTH   = 32,
  parameter NREGS   = 8,
  parameter ISINDEX = 0
) (
  input  wire [WIDTH*NREGS-1:0] regFlat,
  input  wire [2:0]             sel,
  input  wire                   useIt,
  input  wire                   addr32,
  output wire [WIDTH-1:0]       value,
  output reg                    illegal
);

  // Unused port reads as zero so the adder needs no extra gating.
  assign value = useIt ? regFlat[sel*WIDTH +: WIDTH] : {WIDTH{1'b0}};

  // The 32-bit model allows any register except the stack pointer as index;
  // the 16-bit model keeps the legacy base and index pairs.
  always @* begin
    illegal = 1'b0;
    if (useIt) begin
      if (addr32) begin
        illegal = (ISINDEX != 0) && (sel == `EAG_REG_STACK);
      end else if (ISINDEX != 0) begin
        illegal = (sel != `EAG_REG_SI) && (sel != `EAG_REG_DI);
      end else begin
        illegal = (sel != `EAG_REG_BX) && (sel != `EAG_REG_BP);
      end
    end
  end

endmodule // ea_operand_select

// File: ea_sum_stage.v
// Final offset adder: wraps to the address size and flags real-mode over-range.
`timescale 1ns/1ps
`include "eag_consts.vh"

module ea_sum_stage (
  input  wire [31:0] partial,
  input  wire [31:0] disp,
  input  wire        addr32,
  input  wire        realMode,
  output wire [31:0] offset,
  output wire        overRange
);

  wire [31:0] rawSum;

  // Carry out of bit 31 is dropped on purpose.
  assign rawSum    = partial + disp;
  assign offset    = addr32 ? rawSum : (rawSum & `EAG_MASK16);
  // Only a 32-bit form can pass the ceiling; 16-bit forms wrap first.
  assign overRange = realMode && addr32 && (rawSum > `EAG_REAL_LIMIT);

endmodule // ea_sum_stage

// File: eag_checker.sv
// Port assertions for the effective address generator.
`timescale 1ns/1ps
module eag_checker (
  input logic        sys_clk,
  input logic        nrst,
  input logic        psel,
  input logic        penable,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic        reqValid,
  input logic        reqReady,
  input logic        baseUse,
  input logic        indexUse,
  input logic        eaValid,
  input logic [31:0] operandOffset,
  input logic        addrSize32,
  input logic        opSize32,
  input logic        gpFault,
  input logic        formIllegal
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  // Taken requests, and those that pay the extra cycle for base plus index.
  wire take = reqValid && reqReady;
  wire both = baseUse && indexUse;
  property p_one; take && !both |=> !reqReady && !eaValid ##1 eaValid && reqReady; endproperty
  a_one: assert property (p_one) else $error("single form timing");
  property p_two; take && both |=> (!reqReady && !eaValid)[*2] ##1 eaValid && reqReady; endproperty
  a_two: assert property (p_two) else $error("base plus index timing");
  property p_pulse; eaValid |=> !eaValid; endproperty
  a_pulse: assert property (p_pulse) else $error("result pulse too long");
  // Results stand between completions so the next stage sees one instruction at a time.
  property p_hold; !eaValid |-> $stable({operandOffset, addrSize32, opSize32, gpFault, formIllegal}); endproperty
  a_hold: assert property (p_hold) else $error("result moved");
  property p_fault; eaValid && gpFault |-> addrSize32 && operandOffset > 32'h0000FFFF; endproperty
  a_fault: assert property (p_fault) else $error("fault without over-range");
  property p_mask; eaValid && !addrSize32 |-> operandOffset[31:16] == 16'h0000; endproperty
  a_mask: assert property (p_mask) else $error("16-bit offset too wide");
  property p_apb; psel && penable && !pready |=> pready ##1 !pready; endproperty
  a_apb: assert property (p_apb) else $error("register access timing");
  property p_err; pslverr || prdata != 32'h00000000 |-> pready; endproperty
  a_err: assert property (p_err) else $error("response outside completion");
  c_two: cover property (take && both);
  c_fault: cover property (eaValid && gpFault);
  c_ill: cover property (eaValid && formIllegal);
endmodule // eag_checker

bind effective_address_generator eag_checker u_chk (
  .sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .reqValid(reqValid), .reqReady(reqReady), .baseUse(baseUse), .indexUse(indexUse),
  .eaValid(eaValid), .operandOffset(operandOffset), .addrSize32(addrSize32), .opSize32(opSize32),
  .gpFault(gpFault), .formIllegal(formIllegal)
);

// File: eag_decoder_model.sv
// Behavioural instruction decoder that hands offset requests to the generator.
`timescale 1ns/1ps
module eag_decoder_model (
  input  logic        sys_clk,
  input  logic        reqReady,
  output logic        reqValid,
  output logic [45:0] req
);
  // Idle until the first request.
  initial begin
    reqValid = 1'b0;
    req = 46'h0;
  end
  // Presents a request after an optional stall and holds it until taken.
  // Released fields are inverted so a stale value is never mistaken for a live one.
  // A request that is never taken is left to the bench watchdog.
  task automatic issue(input logic [45:0] r, input int gap);
    repeat (gap) @(posedge sys_clk);
    @(posedge sys_clk);
    reqValid <= 1'b1;
    req <= r;
    do begin
      @(posedge sys_clk);
    end while (reqReady !== 1'b1);
    reqValid <= 1'b0;
    req <= ~r;
  endtask
endmodule // eag_decoder_model

// File: effective_address_generator_tb_top.sv
// Self-checking bench for the effective address generator.
`timescale 1ns/1ps
`include "eag_consts.vh"
module effective_address_generator_tb_top;
  // Mode {protected, default size}; request {bu,bs,iu,ix,sc,ds,disp,op,ad}; flags {a32,o32,fault,illegal}.
  typedef struct packed {
    logic [1:0]  md;
    logic [45:0] rq;
    logic [31:0] off;
    logic [3:0]  fl;
  } row_t;
  row_t rows [18] = '{
    '{2'h3,{1'h0,3'h0,1'h1,3'h6,2'h0,2'h1,32'h5,2'h0},32'h25,4'hC},
    '{2'h3,{1'h0,3'h0,1'h1,3'h2,2'h3,2'h3,32'h1000,2'h0},32'h1020,4'hC},
    '{2'h3,{1'h1,3'h0,1'h1,3'h6,2'h0,2'h0,32'h0,2'h0},32'h120,4'hC},
    '{2'h3,{1'h1,3'h3,1'h1,3'h7,2'h2,2'h0,32'h0,2'h0},32'h100C,4'hC},
    '{2'h3,{1'h1,3'h5,1'h1,3'h6,2'h0,2'h3,32'h0FFFFFF0,2'h0},32'h1000F010,4'hC},
    '{2'h3,{1'h1,3'h5,1'h1,3'h7,2'h2,2'h1,32'h80,2'h0},32'hEF8C,4'hC},
    '{2'h3,{1'h1,3'h1,1'h1,3'h3,2'h1,2'h3,32'h80000010,2'h0},32'h2010,4'hC},
    '{2'h2,{1'h1,3'h3,1'h1,3'h6,2'h3,2'h2,32'hFFF0,2'h0},32'h1010,4'h0},
    '{2'h2,{1'h1,3'h5,1'h0,3'h0,2'h0,2'h1,32'hFF,2'h2},32'hEFFF,4'h4},
    '{2'h3,{1'h1,3'h3,1'h1,3'h7,2'h0,2'h1,32'h1,2'h3},32'h1004,4'h0},
    '{2'h1,{1'h1,3'h3,1'h0,3'h0,2'h0,2'h2,32'h2,2'h0},32'h1002,4'h0},
    '{2'h1,{1'h1,3'h0,1'h0,3'h0,2'h0,2'h3,32'hFF00,2'h1},32'h10000,4'hA},
    '{2'h1,{1'h1,3'h0,1'h0,3'h0,2'h0,2'h3,32'hFEFF,2'h1},32'hFFFF,4'h8},
    '{2'h3,{1'h0,3'h0,1'h1,3'h4,2'h0,2'h0,32'h0,2'h0},32'h40,4'hD},
    '{2'h3,{1'h1,3'h0,1'h0,3'h0,2'h0,2'h2,32'h8000,2'h0},32'h8100,4'hD},
    '{2'h2,{1'h1,3'h0,1'h1,3'h6,2'h0,2'h0,32'h0,2'h0},32'h120,4'h1},
    '{2'h2,{1'h1,3'h3,1'h1,3'h2,2'h0,2'h0,32'h0,2'h0},32'h1004,4'h1},
    '{2'h2,{1'h1,3'h3,1'h0,3'h0,2'h0,2'h3,32'h5,2'h0},32'h1005,4'h1}
  };
  logic [31:0] gpv [8] = '{32'h100, 32'h80000000, 32'h4, 32'h1000, 32'h40, 32'hF000, 32'h20, 32'h3};
  logic        sys_clk, nrst, psel, penable, pwrite, pready, pslverr, reqValid, reqReady, rdErr;
  logic        eaValid, addrSize32, opSize32, gpFault, formIllegal;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, operandOffset, rdData;
  logic [45:0] req;
  int          n_fail, n_checks;
  effective_address_generator dut (
    .sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .reqValid(reqValid),
    .baseUse(req[45]), .baseSel(req[44:42]), .indexUse(req[41]), .indexSel(req[40:38]),
    .scaleCode(req[37:36]), .dispSize(req[35:34]), .dispValue(req[33:2]), .opPrefix(req[1]),
    .addrPrefix(req[0]), .reqReady(reqReady), .eaValid(eaValid), .operandOffset(operandOffset),
    .addrSize32(addrSize32), .opSize32(opSize32), .gpFault(gpFault), .formIllegal(formIllegal)
  );
  eag_decoder_model u_dec (.sys_clk(sys_clk), .reqReady(reqReady), .reqValid(reqValid), .req(req));
  // Free-running 50 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Compares one value and counts it.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One register access; the request is held until pready is sampled high.
  // No private limit: a slave that never answers is caught by the watchdog.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Prints the verdict and ends the run.
  task automatic tally_and_finish;
    if (n_fail == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Cuts a hang short; the full sequence needs well under a tenth of this span.
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    tally_and_finish();
  end
  // Main sequence: registers, the request table, then bookkeeping, refusals and a second reset.
  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, `EAG_OFF_GPR_BASE + 8'(4 * i), gpv[i]);
    end
    foreach (rows[i]) begin
      apb(1'b1, `EAG_OFF_CTRL, {30'h0, rows[i].md});
      u_dec.issue(rows[i].rq, i % 2);
      do begin
        @(posedge sys_clk);
      end while (eaValid !== 1'b1);
      chk("offset", rows[i].off, operandOffset);
      chk("flags", {28'h0, rows[i].fl}, {28'h0, addrSize32, opSize32, gpFault, formIllegal});
    end
    apb(1'b0, `EAG_OFF_COUNT, 32'h0);
    chk("count", 32'h12, rdData);
    apb(1'b0, `EAG_OFF_STATUS, 32'h0);
    chk("status", 32'h3, rdData);
    apb(1'b0, `EAG_OFF_RESULT, 32'h0);
    chk("result", 32'h1005, rdData);
    // Any counter write also clears the sticky flags.
    apb(1'b1, `EAG_OFF_COUNT, 32'hFFFFFFFF);
    apb(1'b0, `EAG_OFF_STATUS, 32'h0);
    chk("status cleared", 32'h0, rdData);
    apb(1'b1, `EAG_OFF_STATUS, 32'h1F);
    chk("status write error", 32'h1, {31'h0, rdErr});
    apb(1'b0, 8'h10, 32'h0);
    chk("hole error", 32'h1, {31'h0, rdErr});
    chk("hole data", 32'h0, rdData);
    // Requests are blocked while reset is held, and control falls back to real mode.
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk("ready in reset", 32'h0, {31'h0, reqReady});
    nrst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    apb(1'b0, `EAG_OFF_CTRL, 32'h0);
    chk("control after reset", 32'h0, rdData);
    chk("ready after reset", 32'h1, {31'h0, reqReady});
    tally_and_finish();
  end
endmodule // effective_address_generator_tb_top
